// ---- hw/ssr_regs.svh ----
/*
 * constants of the soft-start ramp sequencer: clock rate, soft-start and
 * retry times, reference codes and step counts.
 * assumes the sense and adjust codes are 8-bit, 0xFF being full scale.
 */
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ************************************************************
// timing
// ************************************************************
`define SSR_CLK_MHZ     100
`define SSR_TSS_US      2000
`define SSR_RETRY_US    1000
`define SSR_STEPS       15

// ************************************************************
// reference codes
// ************************************************************
`define SSR_STEP_W      4
`define SSR_CODE_W      8
`define SSR_STEP_ZERO   4'h0
`define SSR_EXT_STEPS   4'h3
`define SSR_STEP_CODE   8'h11
`define SSR_FULL_CODE   8'hFF
`define SSR_ZERO_CODE   8'h00
`define SSR_FLOOR_CODE  8'h36
`define SSR_EXT_NUM     10'h004
`define SSR_EXT_DEN     10'h005

`endif

// ---- hw/ssr_pkg.sv ----
/*
 * types of the soft-start ramp sequencer.
 * assumes ssr_regs.svh supplies the numeric constants.
 */
package ssr_pkg;

    // ************************************************************
    // sequencer states, one-hot
    // ************************************************************
    typedef enum logic [3:0] {
        st_idle  = 4'h1,
        st_ramp  = 4'h2,
        st_run   = 4'h4,
        st_fault = 4'h8
    } ssr_state_t;

endpackage : ssr_pkg

// ---- hw/ssr_step_timer.sv ----
/*
 * reference ramp step timer: counts oscillator cycles while allowed to
 * advance and steps the ramp index up to its final step.
 * assumes restart and advance come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "ssr_regs.svh"

module ssr_step_timer #(
    parameter int STEP_CYCLES = 13333,
    parameter int STEPS       = `SSR_STEPS
) (
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   restart,
    input  wire logic                   advance,
    output logic [`SSR_STEP_W-1:0]      step,
    output logic                        done
);

    localparam int CW = $clog2(STEP_CYCLES + 1);

    generate
        if (STEP_CYCLES < 1 || STEPS < 1 || STEPS > 15)
        begin : g_chk
            $error("ssr_step_timer: unsupported parameters");
        end
    endgenerate

    logic [CW-1:0]          cnt_r;
    logic [CW-1:0]          cnt_nxt;
    logic [`SSR_STEP_W-1:0] step_r;
    logic [`SSR_STEP_W-1:0] step_nxt;

    // ************************************************************
    // step counting
    // ************************************************************
    always_comb
    begin
        cnt_nxt  = cnt_r;
        step_nxt = step_r;
        if (restart)
        begin
            cnt_nxt  = '0;
            step_nxt = `SSR_STEP_ZERO;
        end
        else if (advance && step_r != 4'(STEPS))
        begin
            // each step lasts one fifteenth of the soft-start time
            if (cnt_r == CW'(STEP_CYCLES - 1))
            begin
                cnt_nxt  = '0;
                step_nxt = step_r + 4'h1;
            end
            else
            begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cnt_r  <= '0;
            step_r <= `SSR_STEP_ZERO;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            step_r <= step_nxt;
        end
    end

    assign step = step_r;
    assign done = step_r == 4'(STEPS);

endmodule : ssr_step_timer

// ---- hw/ssr_sequencer.sv ----
/*
 * soft-start sequencer, on-time extension and loop selection of a
 * peak-current-mode led regulator, running on the internal oscillator.
 * assumes comparator and pin inputs are asynchronous, while the pwm
 * engine level, oscillator pulse and adjust code are on this clock.
 */
`timescale 1ns/1ps
`include "ssr_regs.svh"

module ssr_sequencer #(
    parameter int TSS_CYCLES   = `SSR_TSS_US * `SSR_CLK_MHZ,
    parameter int STEP_CYCLES  = TSS_CYCLES / `SSR_STEPS,
    parameter int RETRY_CYCLES = `SSR_RETRY_US * `SSR_CLK_MHZ
) (
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   dimming_input,
    input  wire logic                   pwm_engine_sel,
    input  wire logic                   pwm_engine_on,
    input  wire logic                   ov_sense_high,
    input  wire logic                   ov_voltage_feedback,
    input  wire logic                   over_temp,
    input  wire logic                   uv_internal_supply,
    input  wire logic                   short_to_ground,
    input  wire logic                   sense_below_ext,
    input  wire logic                   vfb_at_reference,
    input  wire logic                   peak_reached,
    input  wire logic                   osc_pulse,
    input  wire logic                   vloop_enable,
    input  wire logic [`SSR_CODE_W-1:0] adj_ref_code,
    output logic                        gate_drive_output,
    output logic [`SSR_CODE_W-1:0]      current_ref_code,
    output logic [`SSR_CODE_W-1:0]      extension_reference,
    output logic                        voltage_loop_active,
    output logic                        soft_start_active,
    output logic                        extension_active
);

    localparam int NS = 9;
    localparam int TW = $clog2(TSS_CYCLES + 1);
    localparam int RW = $clog2(RETRY_CYCLES + 1);

    generate
        if (STEP_CYCLES < 1 || RETRY_CYCLES < 2 || TSS_CYCLES < 2)
        begin : g_chk
            $error("ssr_sequencer: unsupported parameters");
        end
    endgenerate

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {peak_reached, vfb_at_reference, sense_below_ext,
                        short_to_ground, uv_internal_supply, over_temp,
                        ov_voltage_feedback, ov_sense_high, dimming_input};
            sync2_r <= sync1_r;
        end
    end

    logic dim_s;
    logic ovsh_s;
    logic ovvfb_s;
    logic ot_s;
    logic uv_s;
    logic stg_s;
    logic below_s;
    logic vfb_s;
    logic peak_s;

    assign {peak_s, vfb_s, below_s, stg_s, uv_s, ot_s, ovvfb_s, ovsh_s,
            dim_s} = sync2_r;

    // ************************************************************
    // state
    // ************************************************************
    ssr_pkg::ssr_state_t    st_r;
    ssr_pkg::ssr_state_t    st_nxt;
    logic                   dim_d_r;
    logic                   ext_r;
    logic                   ext_nxt;
    logic [TW-1:0]          on_cnt_r;
    logic [TW-1:0]          on_cnt_nxt;
    logic [TW-1:0]          el_cnt_r;
    logic [TW-1:0]          el_cnt_nxt;
    logic [RW-1:0]          retry_cnt_r;
    logic [RW-1:0]          retry_cnt_nxt;
    logic                   gate_r;
    logic                   gate_nxt;
    logic [`SSR_CODE_W-1:0] cref_r;
    logic [`SSR_CODE_W-1:0] cref_nxt;
    logic [`SSR_CODE_W-1:0] eref_r;
    logic [`SSR_CODE_W-1:0] eref_nxt;
    logic                   vloop_r;
    logic                   vloop_nxt;
    logic                   restart;
    logic                   adv;
    logic [`SSR_STEP_W-1:0] step;
    logic                   step_done;

    // ************************************************************
    // derived conditions
    // ************************************************************
    logic                   dim_lvl;
    logic                   dim_rise;
    logic                   dim_fall;
    logic                   hard_fault;
    logic                   retry_hit;
    logic                   el_done;
    logic                   below_floor;
    logic [`SSR_CODE_W-1:0] ramp_code;
    logic [9:0]             scaled;

    assign dim_lvl     = pwm_engine_sel ? pwm_engine_on : dim_s;
    assign dim_rise    = dim_lvl & ~dim_d_r;
    assign dim_fall    = ~dim_lvl & dim_d_r;
    assign hard_fault  = ovsh_s | ovvfb_s | ot_s | uv_s;
    assign retry_hit   = stg_s && retry_cnt_r == RW'(RETRY_CYCLES - 1);
    assign el_done     = el_cnt_r == TW'(TSS_CYCLES);
    assign below_floor = adj_ref_code < `SSR_FLOOR_CODE;
    assign ramp_code   = {4'h0, step} * `SSR_STEP_CODE;
    assign scaled      = {2'b00, adj_ref_code} * `SSR_EXT_NUM
                         / `SSR_EXT_DEN;

    ssr_step_timer #(
        .STEP_CYCLES (STEP_CYCLES),
        .STEPS       (`SSR_STEPS)
    ) u_step (
        .clock   (clock),
        .resetn  (resetn),
        .restart (restart),
        .advance (adv),
        .step    (step),
        .done    (step_done)
    );

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb
    begin
        st_nxt  = st_r;
        restart = 1'b0;
        case (st_r)
            ssr_pkg::st_idle:
                // waits for the first edge, also the power-up run
                if (dim_rise && !hard_fault)
                begin
                    st_nxt  = ssr_pkg::st_ramp;
                    restart = 1'b1;
                end
            ssr_pkg::st_ramp:
                if (hard_fault)
                    st_nxt = ssr_pkg::st_fault;
                else if (retry_hit)
                    restart = 1'b1;
                else if (step_done)
                    st_nxt = ssr_pkg::st_run;
            ssr_pkg::st_run:
                if (hard_fault)
                    st_nxt = ssr_pkg::st_fault;
                else if (stg_s)
                begin
                    st_nxt  = ssr_pkg::st_ramp;
                    restart = 1'b1;
                end
            ssr_pkg::st_fault:
                if (!hard_fault)
                begin
                    st_nxt  = ssr_pkg::st_ramp;
                    restart = 1'b1;
                end
            default:
                st_nxt = ssr_pkg::st_idle;
        endcase

        // retry period runs only while the short persists
        retry_cnt_nxt = '0;
        if (stg_s && st_r != ssr_pkg::st_idle && !retry_hit)
            retry_cnt_nxt = retry_cnt_r + 1'b1;

        // the ramp only moves while current flows
        adv = st_r == ssr_pkg::st_ramp && (dim_lvl || ext_r)
              && !restart;

        on_cnt_nxt = on_cnt_r;
        if (dim_rise)
            on_cnt_nxt = '0;
        else if (dim_lvl && on_cnt_r != TW'(TSS_CYCLES))
            on_cnt_nxt = on_cnt_r + 1'b1;

        el_cnt_nxt = el_cnt_r;
        if (restart)
            el_cnt_nxt = '0;
        else if (st_r == ssr_pkg::st_ramp && !el_done)
            el_cnt_nxt = el_cnt_r + 1'b1;

        ext_nxt = ext_r;
        if (st_r != ssr_pkg::st_ramp || restart)
            ext_nxt = 1'b0;
        else if (!ext_r)
        begin
            // armed on a dimming falling edge after an on time under the soft-start time with sense below target
            if (dim_fall && on_cnt_r < TW'(TSS_CYCLES) && below_s)
                ext_nxt = 1'b1;
        end
        else if (!below_s)
            ext_nxt = 1'b0;
        else if (below_floor && el_done)
            ext_nxt = 1'b0;

        case (st_r)
            ssr_pkg::st_ramp:
                cref_nxt = (ramp_code < adj_ref_code) ? ramp_code
                                                      : adj_ref_code;
            ssr_pkg::st_run:
                cref_nxt = adj_ref_code;
            default:
                cref_nxt = `SSR_ZERO_CODE;
        endcase

        // the floor keeps the first steps under the extension target
        eref_nxt = (scaled[7:0] < `SSR_FLOOR_CODE) ? `SSR_FLOOR_CODE
                                                   : scaled[7:0];

        vloop_nxt = vloop_enable & vfb_s;

        // peak comparator lags two cycles through its synchroniser
        gate_nxt = gate_r;
        if (!((st_r == ssr_pkg::st_ramp || st_r == ssr_pkg::st_run)
              && (dim_lvl || ext_r) && !restart))
            gate_nxt = 1'b0;
        else if (osc_pulse)
            gate_nxt = 1'b1;
        else if (peak_s)
            gate_nxt = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            st_r        <= ssr_pkg::st_idle;
            dim_d_r     <= 1'b0;
            ext_r       <= 1'b0;
            on_cnt_r    <= '0;
            el_cnt_r    <= '0;
            retry_cnt_r <= '0;
            gate_r      <= 1'b0;
            cref_r      <= `SSR_ZERO_CODE;
            eref_r      <= `SSR_FLOOR_CODE;
            vloop_r     <= 1'b0;
        end
        else
        begin
            st_r        <= st_nxt;
            dim_d_r     <= dim_lvl;
            ext_r       <= ext_nxt;
            on_cnt_r    <= on_cnt_nxt;
            el_cnt_r    <= el_cnt_nxt;
            retry_cnt_r <= retry_cnt_nxt;
            gate_r      <= gate_nxt;
            cref_r      <= cref_nxt;
            eref_r      <= eref_nxt;
            vloop_r     <= vloop_nxt;
        end
    end

    assign gate_drive_output   = gate_r;
    assign current_ref_code    = cref_r;
    assign extension_reference = eref_r;
    assign voltage_loop_active = vloop_r;
    assign soft_start_active   = st_r == ssr_pkg::st_ramp;
    assign extension_active    = ext_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    idle_holds_a: assert property (
        st_r == ssr_pkg::st_idle && !dim_rise |=> st_r == ssr_pkg::st_idle)
        else $error("left idle without an arming edge");
    fault_stops_a: assert property (
        hard_fault && (st_r == ssr_pkg::st_ramp || st_r == ssr_pkg::st_run)
        |=> st_r == ssr_pkg::st_fault ##1 !gate_drive_output)
        else $error("fault did not stop the ramp");
    short_retry_a: assert property (
        retry_hit && st_r == ssr_pkg::st_ramp && !hard_fault
        |=> step == `SSR_STEP_ZERO)
        else $error("short retry did not restart the ramp");
    full_ref_a: assert property (
        st_r == ssr_pkg::st_run && adj_ref_code == `SSR_FULL_CODE
        |=> current_ref_code == `SSR_FULL_CODE)
        else $error("reference not at full scale after ramp");
    ref_capped_a: assert property (
        1'b1 |=> current_ref_code <= $past(adj_ref_code))
        else $error("reference above adjusted level");
    ext_start_a: assert property (
        st_r == ssr_pkg::st_ramp && !restart && !ext_r && dim_fall
        && on_cnt_r < TW'(TSS_CYCLES) && below_s |=> ext_r)
        else $error("short pulse not extended");
    ext_end_a: assert property (
        ext_r && !below_s |=> !ext_r)
        else $error("extension outlived sense target");
    ext_floor_a: assert property (
        extension_reference >= `SSR_FLOOR_CODE)
        else $error("extension reference under floor");
    ext_above_a: assert property (
        st_r == ssr_pkg::st_ramp && step <= `SSR_EXT_STEPS
        |=> extension_reference > current_ref_code)
        else $error("extension reference not above ramp");
    ext_timeout_a: assert property (
        ext_r && below_floor && el_done |=> !ext_r)
        else $error("extension kept past soft-start time");
    ramp_gated_a: assert property (
        !adv && !restart |=> $stable(step))
        else $error("ramp stepped outside an on time");
    vloop_sel_a: assert property (
        voltage_loop_active |-> $past(vloop_enable) && $past(vfb_s))
        else $error("voltage loop active without cause");
    gate_set_a: assert property (
        $rose(gate_drive_output) |-> $past(osc_pulse))
        else $error("gate rose without oscillator pulse");

    arm_c: cover property (st_r == ssr_pkg::st_idle ##1
                           st_r == ssr_pkg::st_ramp);
    ext_c: cover property ($rose(ext_r) ##[1:50] $fell(ext_r));
    retry_c: cover property (retry_hit && st_r == ssr_pkg::st_ramp);
    run_c: cover property (st_r == ssr_pkg::st_ramp ##1
                           st_r == ssr_pkg::st_run);

endmodule : ssr_sequencer

// ---- testbench/ssr_stage_model.sv ----
/*
 * far-side model: dimming source, switching oscillator and peak
 * current comparator of the power stage.
 * assumes the sequencer runs on the same clock as this model.
 */
`timescale 1ns/1ps

module ssr_stage_model #(
    parameter int OSC_PERIOD  = 16,
    parameter int PEAK_CYCLES = 5
) (
    input  wire logic       clock,
    input  wire logic       gate_drive_output,
    input  wire logic       dim_req,
    input  wire logic [7:0] dim_on,
    input  wire logic [7:0] dim_off,
    output logic            dimming_input,
    output logic            osc_pulse,
    output logic            peak_reached
);
    int osc_cnt = 0;
    int dim_cnt = 0;
    int on_cnt  = 0;

    // ********
    // pulse sources
    // ********
    initial
    begin
        dimming_input = 1'b0;
        osc_pulse     = 1'b0;
        peak_reached  = 1'b0;
    end

    always @(posedge clock)
    begin
        osc_cnt   <= (osc_cnt == OSC_PERIOD - 1) ? 0 : osc_cnt + 1;
        osc_pulse <= (osc_cnt == 0);
        on_cnt    <= gate_drive_output ? on_cnt + 1 : 0;
        // peak only after the inductor charged; a stuck gate stays seen
        peak_reached <= gate_drive_output && (on_cnt >= PEAK_CYCLES);
        dim_cnt <= (dim_cnt >= int'(dim_on) + int'(dim_off) - 1) ?
                   0 : dim_cnt + 1;
        dimming_input <= dim_req && (dim_off == 8'h00 || dim_cnt < dim_on);
    end
endmodule : ssr_stage_model

// ---- testbench/testbench.sv ----
/*
 * self-checking bench of the soft-start ramp sequencer.
 * assumes ssr_stage_model plays the dimming pin, oscillator and peak.
 */
`timescale 1ns/1ps
`include "ssr_regs.svh"

module testbench;
    logic       clock            = 1'b0;
    logic       resetn           = 1'b0;
    logic       dim_req          = 1'b0;
    logic [7:0] dim_on           = 8'h05;
    logic [7:0] dim_off          = 8'h00;
    logic       pwm_engine_sel   = 1'b0;
    logic       pwm_engine_on    = 1'b0;
    logic [3:0] faults           = 4'h0;
    logic       short_to_ground  = 1'b0;
    logic       sense_below_ext  = 1'b0;
    logic       vfb_at_reference = 1'b0;
    logic       vloop_enable     = 1'b0;
    logic [7:0] adj_ref_code     = 8'hFF;
    logic       dimming_input, osc_pulse, peak_reached;
    logic       gate_drive_output, voltage_loop_active;
    logic       soft_start_active, extension_active;
    logic [7:0] current_ref_code, extension_reference;
    int         mismatches       = 0;
    int         checked          = 0;

    always #5 clock = ~clock;

    ssr_sequencer #(.TSS_CYCLES(150), .STEP_CYCLES(10),
                    .RETRY_CYCLES(40)) i_dut (
        .clock(clock), .resetn(resetn), .dimming_input(dimming_input),
        .pwm_engine_sel(pwm_engine_sel), .pwm_engine_on(pwm_engine_on),
        .ov_sense_high(faults[0]), .ov_voltage_feedback(faults[1]),
        .over_temp(faults[2]), .uv_internal_supply(faults[3]),
        .short_to_ground(short_to_ground),
        .sense_below_ext(sense_below_ext),
        .vfb_at_reference(vfb_at_reference),
        .peak_reached(peak_reached), .osc_pulse(osc_pulse),
        .vloop_enable(vloop_enable), .adj_ref_code(adj_ref_code),
        .gate_drive_output(gate_drive_output),
        .current_ref_code(current_ref_code),
        .extension_reference(extension_reference),
        .voltage_loop_active(voltage_loop_active),
        .soft_start_active(soft_start_active),
        .extension_active(extension_active));

    ssr_stage_model i_stage (
        .clock(clock), .gate_drive_output(gate_drive_output),
        .dim_req(dim_req), .dim_on(dim_on), .dim_off(dim_off),
        .dimming_input(dimming_input), .osc_pulse(osc_pulse),
        .peak_reached(peak_reached));

    // ********
    // helpers
    // ********
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : check

    function automatic logic pick(input int s);
        case (s)
            0: return soft_start_active;
            1: return extension_active;
            2: return gate_drive_output;
            default: return voltage_loop_active;
        endcase
    endfunction : pick

    task automatic wait_for(input int s, input logic v, input int lim,
                            input string msg);
        int n;
        n = 0;
        // step off the launching edge before the first look
        #1;
        while (pick(s) !== v && n < lim)
        begin
            tick(1);
            n++;
        end
        check(pick(s) === v, msg);
    endtask : wait_for

    task automatic gate_quiet(input int k, input string msg);
        int hi;
        hi = 0;
        repeat (k)
        begin
            tick(1);
            hi += int'(gate_drive_output !== 1'b0);
        end
        check(hi == 0, msg);
    endtask : gate_quiet

    task automatic do_reset();
        @(posedge clock);
        resetn <= 1'b0;
        tick(3);
        @(posedge clock);
        resetn <= 1'b1;
        tick(1);
    endtask : do_reset

    // over-temperature pulse is the cheapest way back to step zero
    task automatic restart();
        @(posedge clock);
        faults <= 4'h4;
        tick(4);
        @(posedge clock);
        faults <= 4'h0;
        wait_for(0, 1'b1, 8, "ramp restart");
    endtask : restart

    // ********
    // scenarios
    // ********
    task automatic t_arm();
        do_reset();
        check(gate_drive_output === 1'b0, "gate after reset");
        check(current_ref_code === `SSR_ZERO_CODE, "ref after reset");
        check(soft_start_active === 1'b0, "idle after reset");
        tick(2);
        check(extension_reference === 8'hCC, "ext ref full");
        @(posedge clock);
        pwm_engine_sel <= 1'b1;
        pwm_engine_on  <= 1'b1;
        wait_for(0, 1'b1, 3, "engine arms");
        @(posedge clock);
        pwm_engine_sel <= 1'b0;
        pwm_engine_on  <= 1'b0;
    endtask : t_arm

    task automatic t_ramp();
        int         n;
        int         steps;
        logic [7:0] prev;
        do_reset();
        @(posedge clock);
        dim_req <= 1'b1;
        wait_for(0, 1'b1, 5, "pin arms");
        n = 0;
        steps = 0;
        prev = current_ref_code;
        while (soft_start_active === 1'b1 && n < 200)
        begin
            check(current_ref_code % `SSR_STEP_CODE == 0, "step code");
            if (current_ref_code <= 8'h33)
                check(extension_reference > current_ref_code, "ext");
            steps += int'(current_ref_code !== prev);
            prev = current_ref_code;
            tick(1);
            n++;
        end
        tick(2);
        steps += int'(current_ref_code !== prev);
        check(steps == 15, "fifteen steps");
        check(current_ref_code === `SSR_FULL_CODE, "full scale");
        check(n >= 145 && n <= 160, "ramp duration");
    endtask : t_ramp

    task automatic t_fault();
        for (int f = 0; f < 4; f++)
        begin
            @(posedge clock);
            faults <= 4'(1 << f);
            // two synchroniser edges plus the state change before gate drops
            tick(3);
            gate_quiet(30, "gate off in fault");
            @(posedge clock);
            faults <= 4'h0;
            wait_for(0, 1'b1, 6, "ramp after fault");
            check(current_ref_code <= `SSR_STEP_CODE, "from zero");
            wait_for(0, 1'b0, 200, "ramp ends");
        end
    endtask : t_fault

    task automatic t_adjust();
        logic       seen;
        int         n;
        int         ev;
        logic [7:0] codes [6];
        codes = '{8'hFF, 8'h80, 8'h44, 8'h40, 8'h20, 8'h00};
        @(posedge clock);
        adj_ref_code <= 8'h80;
        restart();
        seen = 1'b0;
        n = 0;
        while (soft_start_active === 1'b1 && n < 200)
        begin
            check(current_ref_code <= 8'h80, "ref capped");
            seen |= (current_ref_code === 8'h80);
            tick(1);
            n++;
        end
        check(seen === 1'b1, "target before ramp end");
        foreach (codes[i])
        begin
            @(posedge clock);
            adj_ref_code <= codes[i];
            tick(3);
            ev = int'(codes[i]) * 4 / 5;
            ev = (ev < int'(`SSR_FLOOR_CODE)) ? int'(`SSR_FLOOR_CODE) : ev;
            check(extension_reference === 8'(ev), "ext scaling");
        end
        @(posedge clock);
        adj_ref_code <= 8'hFF;
    endtask : t_adjust

    task automatic t_extend();
        logic [7:0] prev;
        @(posedge clock);
        dim_off <= 8'h28;
        restart();
        @(posedge clock);
        sense_below_ext <= 1'b1;
        wait_for(1, 1'b1, 60, "short pulse extended");
        wait_for(2, 1'b1, 40, "gate in extension");
        @(posedge clock);
        sense_below_ext <= 1'b0;
        wait_for(1, 1'b0, 5, "ends at reference");
        @(posedge clock);
        sense_below_ext <= 1'b1;
        wait_for(1, 1'b1, 60, "extension again");
        @(posedge clock);
        sense_below_ext <= 1'b0;
        dim_req <= 1'b0;
        tick(6);
        prev = current_ref_code;
        tick(40);
        check(current_ref_code === prev, "ramp holds while off");
        check(soft_start_active === 1'b1, "ramp outlasts nominal");
        @(posedge clock);
        dim_req <= 1'b1;
        dim_off <= 8'h00;
        wait_for(0, 1'b0, 200, "ramp completes");
    endtask : t_extend

    task automatic t_floor();
        @(posedge clock);
        adj_ref_code <= 8'h20;
        dim_off <= 8'h28;
        restart();
        @(posedge clock);
        sense_below_ext <= 1'b1;
        wait_for(1, 1'b1, 60, "extension low adjust");
        wait_for(1, 1'b0, 200, "ends after tss");
        @(posedge clock);
        sense_below_ext <= 1'b0;
        adj_ref_code <= 8'hFF;
        dim_off <= 8'h00;
        wait_for(0, 1'b0, 200, "ramp completes");
    endtask : t_floor

    task automatic t_short();
        int n;
        @(posedge clock);
        short_to_ground <= 1'b1;
        wait_for(0, 1'b1, 6, "short restarts");
        tick(20);
        check(current_ref_code !== `SSR_ZERO_CODE, "ramp climbs");
        n = 0;
        while (current_ref_code !== `SSR_ZERO_CODE && n < 50)
        begin
            tick(1);
            n++;
        end
        check(current_ref_code === `SSR_ZERO_CODE, "retry");
        @(posedge clock);
        short_to_ground <= 1'b0;
        wait_for(0, 1'b0, 220, "ramp completes");
    endtask : t_short

    task automatic t_loops();
        @(posedge clock);
        vloop_enable <= 1'b1;
        vfb_at_reference <= 1'b1;
        wait_for(3, 1'b1, 5, "voltage loop on");
        @(posedge clock);
        vfb_at_reference <= 1'b0;
        wait_for(3, 1'b0, 5, "current loop back");
        @(posedge clock);
        vloop_enable <= 1'b0;
        vfb_at_reference <= 1'b1;
        tick(5);
        check(voltage_loop_active === 1'b0, "loop disabled");
        wait_for(2, 1'b1, 40, "oscillator sets gate");
        wait_for(2, 1'b0, 12, "peak ends pulse");
        @(posedge clock);
        dim_req <= 1'b0;
        tick(6);
        gate_quiet(40, "gate off while dim off");
    endtask : t_loops

    // ********
    // run
    // ********
    task automatic print_verdict();
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        t_arm();
        t_ramp();
        t_fault();
        t_adjust();
        t_extend();
        t_floor();
        t_short();
        t_loops();
        print_verdict();
    end

    initial
    begin
        #300000;
        mismatches++;
        print_verdict();
    end
endmodule : testbench
